// >>> common/pmrc_defines.svh
/*
 Timing counts, register offsets, field positions and reset values for the
 payload and management reset controller. Assumes a 100 MHz controller clock.
*/
`ifndef PMRC_DEFINES_SVH
`define PMRC_DEFINES_SVH

`define PMRC_CLK_MHZ          100
`define PMRC_DEBOUNCE_MS      50
`define PMRC_DEBOUNCE_CYC     (`PMRC_DEBOUNCE_MS * 1000 * `PMRC_CLK_MHZ)
`define PMRC_HWDOG_MS         1000
`define PMRC_HWDOG_CYC        (`PMRC_HWDOG_MS * 1000 * `PMRC_CLK_MHZ)
`define PMRC_BOOTFAIL_MS      5000
`define PMRC_BOOTFAIL_CYC     (`PMRC_BOOTFAIL_MS * 1000 * `PMRC_CLK_MHZ)
`define PMRC_INIT_PCICLK      16
`define PMRC_PCI_MHZ          33
`define PMRC_INIT_CYC \
   ((`PMRC_INIT_PCICLK * `PMRC_CLK_MHZ + `PMRC_PCI_MHZ - 1) / `PMRC_PCI_MHZ)
`define PMRC_HARD_CYC         100
`define PMRC_MGMT_CYC         16

`define PMRC_ADR_CTRL         8'h00
`define PMRC_ADR_CMD          8'h04
`define PMRC_ADR_STATUS       8'h08
`define PMRC_ADR_EVENT        8'h0C

`define PMRC_CTRL_HWDOG_KICK  0
`define PMRC_CTRL_HOSTDOG_RST 1
`define PMRC_CTRL_XFER_EXIT   2
`define PMRC_CTRL_BOOTDOG_ON  3
`define PMRC_CTRL_RESET       32'h0000_0002

`define PMRC_CMD_FRU_GO       2
`define PMRC_CMD_FRU_LSB      0
`define PMRC_CMD_CHASSIS_HARD 3
`define PMRC_CMD_CPU_DISABLE  4
`define PMRC_CMD_COLD_MGMT    5
`define PMRC_CMD_ACTIVATE     6
`define PMRC_CMD_POWER_OFF    7
`define PMRC_CMD_OS_WARM      8
`define PMRC_CMD_FPGA_CHANGE  9
`define PMRC_CMD_UPD_COMBINED 10
`define PMRC_CMD_CLR_ATTN     11
`define PMRC_CMD_PEF          12

`endif

// >>> common/pmrc_pkg.sv
/*
 Types for the payload and management reset controller.
 Assumes the constants header is included by the design file.
*/
package pmrc_pkg;
   typedef enum logic [1:0] {
      PMRC_FRU_COLD = 2'h0,
      PMRC_FRU_WARM = 2'h1,
      PMRC_FRU_REBOOT = 2'h2,
      PMRC_FRU_DIAG = 2'h3
   } pmrc_fru_e;
   typedef enum logic [1:0] {
      PMRC_IDLE = 2'b00,
      PMRC_SOFT = 2'b01,
      PMRC_HARD = 2'b11,
      PMRC_MGMT = 2'b10
   } pmrc_state_e;
endpackage

// >>> logic/pmrc_reset_ctrl.sv
/*
 Payload and management controller reset sequencer with a classic Wishbone
 register slave. Assumes a single 100 MHz clock; button and strap inputs are
 asynchronous pins and are synchronised here.
*/
`timescale 1ns/1ps
`include "pmrc_defines.svh"

module pmrc_reset_ctrl #(
   parameter int DEBOUNCE_CYC = `PMRC_DEBOUNCE_CYC,
   parameter int HWDOG_CYC    = `PMRC_HWDOG_CYC,
   parameter int BOOTFAIL_CYC = `PMRC_BOOTFAIL_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        reset_button_n,
   input  wire logic        force_update,
   input  wire logic        checksum_ok,
   input  wire logic        host_watchdog_expired,
   input  wire logic        payload_power_good,
   input  wire logic        payload_init_n_in,
   output logic             payload_init_n,
   output logic             payload_sys_reset_n,
   output logic             diag_interrupt,
   output logic             system_software_attention_flag,
   output logic             mgmt_core_reset,
   output logic             mgmt_bus_isolate,
   output logic             firmware_transfer_mode
);

   if (DEBOUNCE_CYC < 2 || HWDOG_CYC < 2 || BOOTFAIL_CYC < 2) begin : g_bad_counts
      $error("pmrc_reset_ctrl: counts must be at least 2");
   end

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [4:0] sync1;
   logic [4:0] sync2;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
      end else begin
         sync1 <= {payload_power_good, payload_init_n_in, checksum_ok, force_update,
                   ~reset_button_n};
         sync2 <= sync1;
      end
   end
   logic btn_raw;
   logic force_s;
   logic csum_s;
   logic init_pin_s;
   logic pg_s;
   assign pg_s       = sync2[4];
   assign btn_raw    = sync2[0];
   assign force_s    = sync2[1];
   assign csum_s     = sync2[2];
   assign init_pin_s = sync2[3];

   // ----------------------------------------------------------------
   // Button debounce
   // ----------------------------------------------------------------
   logic [31:0] db_cnt;
   logic        btn_state;
   logic        btn_press;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         db_cnt    <= 32'h0000_0000;
         btn_state <= 1'b0;
      end else if (btn_raw == btn_state) begin
         db_cnt <= 32'h0000_0000;
      end else if (db_cnt == 32'(DEBOUNCE_CYC - 1)) begin
         db_cnt    <= 32'h0000_0000;
         btn_state <= btn_raw;
      end else begin
         db_cnt <= db_cnt + 32'h0000_0001;
      end
   end
   assign btn_press = (btn_raw != btn_state) && (db_cnt == 32'(DEBOUNCE_CYC - 1)) && btn_raw;

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   logic        wr;
   logic        cmd_wr;
   logic [31:0] ctrl;
   logic        hwdog_kick;
   logic        xfer_exit;
   logic        hostdog_rst_en;
   logic        bootdog_on;
   logic        hwdog_event;
   logic        fpga_pending;
   assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   assign cmd_wr = wr && wb_adr_i == `PMRC_ADR_CMD;
   assign hwdog_kick = wr && wb_adr_i == `PMRC_ADR_CTRL
                       && wb_dat_i[`PMRC_CTRL_HWDOG_KICK];
   assign xfer_exit  = wr && wb_adr_i == `PMRC_ADR_CTRL
                       && wb_dat_i[`PMRC_CTRL_XFER_EXIT];
   assign hostdog_rst_en = ctrl[`PMRC_CTRL_HOSTDOG_RST];
   assign bootdog_on     = ctrl[`PMRC_CTRL_BOOTDOG_ON];

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl <= `PMRC_CTRL_RESET;
      end else if (wr && wb_adr_i == `PMRC_ADR_CTRL) begin
         ctrl <= {28'h000_0000, wb_dat_i[3], wb_dat_i[2:1], 1'b0} & 32'h0000_000A;
      end
   end

   // Command decode: one pulse per written command word
   logic [3:0]             op;
   pmrc_pkg::pmrc_fru_e    fru_val;
   assign op      = wb_dat_i[7:4];
   assign fru_val = pmrc_pkg::pmrc_fru_e'(wb_dat_i[1:0]);
   logic fru_go;
   assign fru_go = cmd_wr && wb_dat_i[`PMRC_CMD_FRU_GO];

   logic req_hard;
   logic req_soft;
   logic req_mgmt;
   logic bootfail_exp;
   logic hwdog_exp;
   logic reboot_req;
   assign reboot_req = fru_go && fru_val == pmrc_pkg::PMRC_FRU_REBOOT;
   assign req_hard = btn_press
      || (cmd_wr && op == 4'(`PMRC_CMD_CHASSIS_HARD))
      || (cmd_wr && op == 4'(`PMRC_CMD_CPU_DISABLE))
      || (cmd_wr && op == 4'(`PMRC_CMD_PEF))
      || (fru_go && fru_val == pmrc_pkg::PMRC_FRU_COLD)
      || (host_watchdog_expired && hostdog_rst_en)
      || (cmd_wr && op == 4'(`PMRC_CMD_ACTIVATE))
      || (cmd_wr && op == 4'(`PMRC_CMD_POWER_OFF))
      || (cmd_wr && op == 4'(`PMRC_CMD_FPGA_CHANGE))
      || (cmd_wr && op == 4'(`PMRC_CMD_UPD_COMBINED))
      || bootfail_exp;
   assign req_soft = (fru_go && fru_val == pmrc_pkg::PMRC_FRU_WARM)
      || (cmd_wr && op == 4'(`PMRC_CMD_OS_WARM));
   // Host watchdog expiry is deliberately absent from this term
   assign req_mgmt = hwdog_exp || xfer_exit
      || (cmd_wr && op == 4'(`PMRC_CMD_COLD_MGMT))
      || (cmd_wr && op == 4'(`PMRC_CMD_UPD_COMBINED));

   // ----------------------------------------------------------------
   // Pending requests and sequencer
   // ----------------------------------------------------------------
   logic pend_hard;
   logic pend_soft;
   logic pend_mgmt;
   pmrc_pkg::pmrc_state_e state;
   logic [15:0] seq_cnt;
   logic        seq_done;
   assign seq_done = seq_cnt == 16'h0000;

   // Set wins over the clear taken when a sequence starts
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pend_hard <= 1'b0;
         pend_soft <= 1'b0;
         pend_mgmt <= 1'b0;
      end else begin
         pend_hard <= req_hard || (pend_hard && !(state == pmrc_pkg::PMRC_IDLE));
         pend_soft <= req_soft || (pend_soft && !(state == pmrc_pkg::PMRC_IDLE && !pend_hard));
         pend_mgmt <= req_mgmt || (pend_mgmt && !(state == pmrc_pkg::PMRC_IDLE
                      && !pend_hard && !pend_soft));
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state   <= pmrc_pkg::PMRC_IDLE;
         seq_cnt <= 16'h0000;
      end else begin
         unique case (state)
            pmrc_pkg::PMRC_IDLE: begin
               if (pend_hard) begin
                  state   <= pmrc_pkg::PMRC_HARD;
                  seq_cnt <= 16'(`PMRC_HARD_CYC - 1);
               end else if (pend_soft) begin
                  state   <= pmrc_pkg::PMRC_SOFT;
                  seq_cnt <= 16'(`PMRC_INIT_CYC - 1);
               end else if (pend_mgmt) begin
                  state   <= pmrc_pkg::PMRC_MGMT;
                  seq_cnt <= 16'(`PMRC_MGMT_CYC - 1);
               end
            end
            pmrc_pkg::PMRC_SOFT,
            pmrc_pkg::PMRC_HARD,
            pmrc_pkg::PMRC_MGMT: begin
               if (seq_done) begin
                  state <= pmrc_pkg::PMRC_IDLE;
               end else begin
                  seq_cnt <= seq_cnt - 16'h0001;
               end
            end
         endcase
      end
   end

   // Outputs are flopped; reset puts them in the released state
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         payload_sys_reset_n <= 1'b1;
         payload_init_n      <= 1'b1;
         mgmt_core_reset     <= 1'b0;
      end else begin
         payload_sys_reset_n <= !(state == pmrc_pkg::PMRC_HARD);
         payload_init_n      <= !(state == pmrc_pkg::PMRC_SOFT);
         mgmt_core_reset     <= state == pmrc_pkg::PMRC_MGMT;
      end
   end
   // Isolation also covers the external reset, when the core is down too
   assign mgmt_bus_isolate = rst || mgmt_core_reset;

   // ----------------------------------------------------------------
   // Diagnostic interrupt and attention flag
   // ----------------------------------------------------------------
   logic clr_attn;
   assign clr_attn = cmd_wr && op == 4'(`PMRC_CMD_CLR_ATTN);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         system_software_attention_flag <= 1'b0;
         diag_interrupt                 <= 1'b0;
      end else begin
         system_software_attention_flag <= reboot_req
            || (system_software_attention_flag && !clr_attn);
         diag_interrupt <= fru_go && fru_val == pmrc_pkg::PMRC_FRU_DIAG;
      end
   end

   // ----------------------------------------------------------------
   // Internal hardware watchdog
   // ----------------------------------------------------------------
   logic [31:0] hw_cnt;
   assign hwdog_exp = hw_cnt == 32'(HWDOG_CYC - 1) && !hwdog_kick;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hw_cnt <= 32'h0000_0000;
      end else if (hwdog_kick || hwdog_exp || state == pmrc_pkg::PMRC_MGMT) begin
         hw_cnt <= 32'h0000_0000;
      end else begin
         hw_cnt <= hw_cnt + 32'h0000_0001;
      end
   end
   // Survives the controller reset pulse; cleared by writing 1 to event bit 0, not by a read
   logic clr_event;
   assign clr_event = wr && wb_adr_i == `PMRC_ADR_EVENT && wb_dat_i[0];
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hwdog_event <= 1'b0;
      end else begin
         hwdog_event <= hwdog_exp || (hwdog_event && !clr_event);
      end
   end

   // ----------------------------------------------------------------
   // Boot failure timer
   // ----------------------------------------------------------------
   logic [31:0] bf_cnt;
   logic        bf_run;
   assign bootfail_exp = bf_run && !bootdog_on && bf_cnt == 32'(BOOTFAIL_CYC - 1);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bf_run <= 1'b0;
         bf_cnt <= 32'h0000_0000;
      end else if (state == pmrc_pkg::PMRC_HARD || state == pmrc_pkg::PMRC_SOFT) begin
         bf_run <= 1'b1;
         bf_cnt <= 32'h0000_0000;
      end else if (bootdog_on || bootfail_exp) begin
         bf_run <= 1'b0;
         bf_cnt <= 32'h0000_0000;
      end else if (bf_run) begin
         bf_cnt <= bf_cnt + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // Firmware transfer mode
   // ----------------------------------------------------------------
   // Straps are trusted only once both synchroniser stages hold pin levels
   logic [2:0] init_sr;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         firmware_transfer_mode <= 1'b0;
         init_sr                <= 3'h0;
         fpga_pending           <= 1'b0;
      end else begin
         init_sr <= {init_sr[1:0], 1'b1};
         if (init_sr == 3'h3 || state == pmrc_pkg::PMRC_MGMT) begin
            firmware_transfer_mode <= force_s || !csum_s;
         end else if (xfer_exit) begin
            firmware_transfer_mode <= 1'b0;
         end
         fpga_pending <= (cmd_wr && op == 4'(`PMRC_CMD_FPGA_CHANGE))
                         || (fpga_pending && state != pmrc_pkg::PMRC_HARD);
      end
   end

   // ----------------------------------------------------------------
   // Read mux and acknowledge
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         unique case (wb_adr_i)
            `PMRC_ADR_CTRL:   wb_dat_o <= ctrl;
            `PMRC_ADR_STATUS: wb_dat_o <= {20'h0_0000, init_pin_s, pg_s,
                                 fpga_pending, firmware_transfer_mode, 1'b0,
                                 system_software_attention_flag, bf_run,
                                 pend_mgmt, pend_soft, pend_hard, state};
            `PMRC_ADR_EVENT:  wb_dat_o <= {31'h0000_0000, hwdog_event};
            default:          wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence hard_start_s;
      state == pmrc_pkg::PMRC_IDLE && pend_hard;
   endsequence
   hard_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
      hard_start_s |=> ##1 !payload_sys_reset_n)
      else $error("hard reset not driven");
   hard_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
      hard_start_s |=> state == pmrc_pkg::PMRC_HARD)
      else $error("hard reset lost priority");
   soft_init_a: assert property (@(posedge ref_clk) disable iff (rst)
      state == pmrc_pkg::PMRC_IDLE && pend_soft && !pend_hard |=> ##1
      !payload_init_n && payload_sys_reset_n)
      else $error("soft reset wrong pins");
   hostdog_no_mgmt_a: assert property (@(posedge ref_clk) disable iff (rst)
      host_watchdog_expired && !pend_mgmt && state != pmrc_pkg::PMRC_MGMT
      && !hwdog_exp && !wr |=> !pend_mgmt ##1 state != pmrc_pkg::PMRC_MGMT)
      else $error("host watchdog hit controller");
   attn_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      reboot_req |=> system_software_attention_flag)
      else $error("attention flag not set");
   hwdog_fire_a: assert property (@(posedge ref_clk) disable iff (rst)
      hwdog_exp && state == pmrc_pkg::PMRC_IDLE && !pend_hard && !pend_soft
      && !req_hard && !req_soft |=> pend_mgmt ##1 1 ##[0:2] mgmt_core_reset)
      else $error("watchdog did not reset core");
   sequence mgmt_start_s;
      state == pmrc_pkg::PMRC_IDLE && pend_mgmt && !pend_hard && !pend_soft;
   endsequence
   isolate_bus_a: assert property (@(posedge ref_clk) disable iff (rst)
      mgmt_start_s |=> ##1 mgmt_bus_isolate [*8])
      else $error("bus not isolated");
   button_hard_a: assert property (@(posedge ref_clk) disable iff (rst)
      btn_press |=> pend_hard)
      else $error("button press ignored");
   fru_cold_a: assert property (@(posedge ref_clk) disable iff (rst)
      fru_go && fru_val == pmrc_pkg::PMRC_FRU_COLD |=> pend_hard)
      else $error("cold reset ignored");
endmodule

// >>> tb/pmrc_payload_model.sv
/*
 Payload side model: the init line and power rail seen by the reset
 controller, with a monitor of reset pulse counts and lengths.
 Assumes the controller pins and its 100 MHz clock.
*/
`timescale 1ns/1ps
module pmrc_payload_model (
   input  wire logic        ref_clk,
   input  wire logic        payload_init_n,
   input  wire logic        payload_sys_reset_n,
   output logic             payload_init_n_in,
   output logic             payload_power_good,
   output logic [15:0]      hard_cnt,
   output logic [15:0]      hard_len,
   output logic [15:0]      soft_cnt,
   output logic [15:0]      soft_len
);
   logic [15:0] hrun;
   logic [15:0] srun;
   // Init line has a pull-up; only the controller pulls it low
   assign payload_init_n_in  = payload_init_n;
   // Rails stay good: no source in this model removes standby power
   assign payload_power_good = 1'b1;
   initial begin
      {hrun, srun, hard_cnt, hard_len, soft_cnt, soft_len} = 96'h0;
   end
   // Length in clocks is recorded when a low pulse ends
   always @(posedge ref_clk) begin
      if (!payload_sys_reset_n) begin
         hrun <= hrun + 16'h0001;
      end else if (hrun != 16'h0000) begin
         hard_cnt <= hard_cnt + 16'h0001;
         hard_len <= hrun;
         hrun     <= 16'h0000;
      end
      if (!payload_init_n) begin
         srun <= srun + 16'h0001;
      end else if (srun != 16'h0000) begin
         soft_cnt <= soft_cnt + 16'h0001;
         soft_len <= srun;
         srun     <= 16'h0000;
      end
   end
endmodule

// >>> tb/pmrc_reset_ctrl_tb.sv
/*
 Self-checking bench for the reset controller: Wishbone register access,
 command table, button, watchdogs and transfer mode.
 Assumes shortened counts: debounce 20, hw watchdog 200, boot timer 300.
*/
`timescale 1ns/1ps
`include "pmrc_defines.svh"
module pmrc_reset_ctrl_tb;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
   logic        reset_button_n = 1'b1, force_update = 1'b0, host_watchdog_expired = 1'b0;
   logic        payload_power_good, payload_init_n_in, payload_init_n, payload_sys_reset_n;
   logic        diag_interrupt, system_software_attention_flag, wb_ack_o;
   logic        mgmt_core_reset, mgmt_bus_isolate, firmware_transfer_mode;
   logic [15:0] hard_cnt, hard_len, soft_cnt, soft_len, h0, s0;
   logic [11:0] e;
   int          n_mismatch = 0, n_tests = 0, cyc_cnt = 0, m0, d0;
   int          mgmt_cnt = 0, mlen = 0, mrun = 0, diag_cnt = 0, iso_bad = 0;
   // {command byte, hard, soft, controller, diagnostic}
   localparam logic [11:0] TBL [0:11] = '{12'h048, 12'h054, 12'h071, 12'h308, 12'h408,
      12'h608, 12'h708, 12'h804, 12'h908, 12'h502, 12'hA0A, 12'hC08};

   pmrc_reset_ctrl #(.DEBOUNCE_CYC(20), .HWDOG_CYC(200), .BOOTFAIL_CYC(300)) uut (
      .ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .reset_button_n, .force_update, .checksum_ok(1'b1),
      .host_watchdog_expired, .payload_power_good, .payload_init_n_in, .payload_init_n,
      .payload_sys_reset_n, .diag_interrupt, .system_software_attention_flag,
      .mgmt_core_reset, .mgmt_bus_isolate, .firmware_transfer_mode);
   pmrc_payload_model payload (.ref_clk, .payload_init_n, .payload_sys_reset_n,
      .payload_init_n_in, .payload_power_good, .hard_cnt, .hard_len, .soft_cnt, .soft_len);

   // ---------------------------------------------------------------
   // Clock, monitors and hang limit
   // ---------------------------------------------------------------
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (cyc_cnt == 10000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   always @(posedge ref_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (mgmt_core_reset === 1'b1) begin
         mrun <= mrun + 1;
         if (mgmt_bus_isolate !== 1'b1) iso_bad <= iso_bad + 1;
      end else if (mrun != 0) begin
         mgmt_cnt <= mgmt_cnt + 1;
         mlen     <= mrun;
         mrun     <= 0;
      end
      if (diag_interrupt === 1'b1) diag_cnt <= diag_cnt + 1;
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits for ack without assuming a latency; only the hang limit ends it
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hF, d};
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   // Refresh, host reset action on, boot failure timer held off
   task automatic kick();
      wb(1'b1, `PMRC_ADR_CTRL, 32'h0000_000B);
   endtask
   task automatic snap();
      {h0, s0, m0, d0} = {hard_cnt, soft_cnt, mgmt_cnt, diag_cnt};
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge ref_clk);
      chk({mgmt_bus_isolate, payload_init_n, payload_sys_reset_n}, 3'b111);
      rst <= 1'b0;
      wb(1'b0, `PMRC_ADR_CTRL, 32'h0);
      chk(q, `PMRC_CTRL_RESET);
      wb(1'b0, `PMRC_ADR_STATUS, 32'h0);
      chk({q[11:10], q[8], q[6], q[1:0]}, 6'b110000);
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0000_0000);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         e = TBL[i];
         kick();
         snap();
         wb(1'b1, `PMRC_ADR_CMD, {24'h00_0000, e[11:4]});
         repeat (140) @(posedge ref_clk);
         chk({hard_cnt - h0, soft_cnt - s0}, {15'h0, e[3], 15'h0, e[2]});
         chk({16'(mgmt_cnt - m0), 16'(diag_cnt - d0)},
             {15'h0, e[1], 15'h0, e[0]});
         if (e[3]) chk(hard_len, `PMRC_HARD_CYC);
         if (e[2]) chk(soft_len, `PMRC_INIT_CYC);
         if (e[1]) chk(mlen, `PMRC_MGMT_CYC);
      end
      chk(iso_bad, 0);
      $display("test commands done");
      kick();
      wb(1'b1, `PMRC_ADR_CMD, 32'h0000_0006);
      repeat (5) @(posedge ref_clk);
      chk(system_software_attention_flag, 1'b1);
      wb(1'b1, `PMRC_ADR_CMD, 32'h0000_00B0);
      repeat (5) @(posedge ref_clk);
      chk(system_software_attention_flag, 1'b0);
      $display("test reboot message done");
      kick();
      snap();
      reset_button_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      reset_button_n <= 1'b1;
      repeat (40) @(posedge ref_clk);
      chk(hard_cnt - h0, 16'h0000);
      kick();
      reset_button_n <= 1'b0;
      repeat (30) @(posedge ref_clk);
      reset_button_n <= 1'b1;
      repeat (140) @(posedge ref_clk);
      chk(hard_cnt - h0, 16'h0001);
      $display("test button done");
      kick();
      snap();
      host_watchdog_expired <= 1'b1;
      @(posedge ref_clk);
      host_watchdog_expired <= 1'b0;
      repeat (130) @(posedge ref_clk);
      chk({hard_cnt - h0, 16'(mgmt_cnt - m0)}, 32'h0001_0000);
      $display("test host watchdog done");
      wb(1'b1, `PMRC_ADR_CTRL, 32'h0000_0003);
      snap();
      wb(1'b1, `PMRC_ADR_CMD, 32'h0000_0030);
      repeat (4) begin
         wb(1'b1, `PMRC_ADR_CTRL, 32'h0000_0003);
         repeat (130) @(posedge ref_clk);
      end
      chk(hard_cnt - h0, 16'h0002);
      $display("test boot timer done");
      kick();
      snap();
      force_update <= 1'b1;
      wb(1'b1, `PMRC_ADR_CMD, 32'h0000_0050);
      repeat (40) @(posedge ref_clk);
      chk(firmware_transfer_mode, 1'b1);
      force_update <= 1'b0;
      wb(1'b1, `PMRC_ADR_CTRL, 32'h0000_000F);
      repeat (40) @(posedge ref_clk);
      chk({firmware_transfer_mode, 8'(mgmt_cnt - m0), hard_cnt - h0}, 25'h002_0000);
      $display("test transfer mode done");
      snap();
      repeat (215) @(posedge ref_clk);
      chk(mgmt_cnt - m0, 1);
      wb(1'b0, `PMRC_ADR_EVENT, 32'h0);
      chk(q[0], 1'b1);
      wb(1'b1, `PMRC_ADR_EVENT, 32'h0000_0001);
      wb(1'b0, `PMRC_ADR_EVENT, 32'h0);
      chk(q[0], 1'b0);
      $display("test hardware watchdog done");
      give_verdict();
   end
endmodule
